/* File: design/tscr_code_slot.sv */
`timescale 1ns/1ps
// ****************************************************************************
// One coded status register: holds the last code until cleared or replaced.
// ****************************************************************************
module tscr_code_slot (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] load_code,
  output logic [7:0] code_q
);

  typedef struct packed {
    logic [7:0] code;
  } tscr_slot_s;

  tscr_slot_s state_reg;
  tscr_slot_s state_next;

  // A new code wins over a clear in the same cycle so no event is lost.
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.code = load_code;
    end else if (clear) begin
      state_next.code = tscr_pkg::TSCR_CODE_NONE;
    end
  end

  // State register, zero after reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{code: tscr_pkg::TSCR_CODE_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign code_q = state_reg.code;

  a_slot_hold_value: assert property (@(posedge clock) disable iff (!rst_b)
    (!load && !clear) |=> code_q == $past(code_q))
    else $error("Status code changed without a load or a clear.");

  a_slot_load_wins: assert property (@(posedge clock) disable iff (!rst_b)
    load |=> code_q == $past(load_code))
    else $error("Loaded status code was not stored.");

endmodule

/* File: design/tscr_status_regs.sv */
`timescale 1ns/1ps
module tscr_status_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic histogram_ram_selftest_fail,
  input wire logic measurement_stop_failed,
  input wire logic sleep_timer_range_fault,
  input wire logic unplanned_reset_seen,
  input wire logic unprogrammed_fuse_warning,
  input wire logic emitter_eye_safety_fault,
  input wire logic breakdown_voltage_search_fault,
  input wire logic extra_configuration_fault,
  input wire logic start_before_setup_fault,
  input wire logic buffer_double_return_fault,
  input wire logic converter_lockup_fault,
  input wire logic electrical_cal_fault,
  input wire logic electrical_cal_missing_buffer,
  input wire logic electrical_cal_index_mismatch,
  input wire logic absent_factory_cal_warning,
  input wire logic factory_cal_mask_mismatch,
  output logic measurement_forced_shutdown,
  output logic status_nonzero_irq_flag,
  output logic int_pin_o,
  output logic int_pin_oe_b
);

  // **************************************************************************
  // State of the block.
  // **************************************************************************
  typedef struct packed {
    logic irq_flag;
    logic irq_mask;
    logic [7:0] rdata;
    logic rvalid;
    logic shutdown;
  } tscr_state_s;

  tscr_state_s state_reg;
  tscr_state_s state_next;

  logic [5:0] app_ev;
  logic [5:0] meas_ev;
  logic [5:0] alg_ev;
  logic [5:0] cal_ev;
  logic [7:0] app_load_code;
  logic [7:0] meas_load_code;
  logic [7:0] alg_load_code;
  logic [7:0] cal_load_code;
  logic app_load;
  logic meas_load;
  logic alg_load;
  logic cal_load;
  logic clear_all;
  logic any_nonzero_load;
  logic [7:0] app_code;
  logic [7:0] meas_code;
  logic [7:0] alg_code;
  logic [7:0] cal_code;

  // **************************************************************************
  // Event collection and encoding.
  // **************************************************************************

  // Each register gathers its events in priority order, lowest code first.
  assign app_ev = {1'b0, unprogrammed_fuse_warning, unplanned_reset_seen,
                   sleep_timer_range_fault, measurement_stop_failed,
                   histogram_ram_selftest_fail};
  assign meas_ev = {converter_lockup_fault, buffer_double_return_fault,
                    start_before_setup_fault, extra_configuration_fault,
                    breakdown_voltage_search_fault, emitter_eye_safety_fault};
  assign alg_ev = {3'h0, electrical_cal_index_mismatch,
                   electrical_cal_missing_buffer, electrical_cal_fault};
  assign cal_ev = {4'h0, factory_cal_mask_mismatch, absent_factory_cal_warning};

  // Only listed codes come out of the tables; deprecated ones have no entry.
  assign app_load_code = tscr_pkg::tscr_pick(app_ev, tscr_pkg::TSCR_APP_CODES,
                                             tscr_pkg::TSCR_APP_N);
  assign meas_load_code = tscr_pkg::tscr_pick(meas_ev, tscr_pkg::TSCR_MEAS_CODES,
                                              tscr_pkg::TSCR_MEAS_N);
  assign alg_load_code = tscr_pkg::tscr_pick(alg_ev, tscr_pkg::TSCR_ALG_CODES,
                                             tscr_pkg::TSCR_ALG_N);
  assign cal_load_code = tscr_pkg::tscr_pick(cal_ev, tscr_pkg::TSCR_CAL_CODES,
                                             tscr_pkg::TSCR_CAL_N);

  // A register loads only when one of its events fires.
  assign app_load = |app_ev;
  assign meas_load = |meas_ev;
  assign alg_load = |alg_ev;
  assign cal_load = |cal_ev;

  // Clear-status and measurement-start commands both clear all four code registers.
  assign clear_all = reg_wr && reg_addr == tscr_pkg::TSCR_OFF_CMD &&
                     (reg_wdata == tscr_pkg::TSCR_CMD_CLEAR ||
                      reg_wdata == tscr_pkg::TSCR_CMD_MEASURE);

  // Any register taking a nonzero code raises the status flag.
  assign any_nonzero_load = app_load || meas_load || alg_load || cal_load;

  // **************************************************************************
  // The four coded status registers.
  // **************************************************************************
  tscr_code_slot u_app_slot (
    .clock(clock),
    .rst_b(rst_b),
    .clear(clear_all),
    .load(app_load),
    .load_code(app_load_code),
    .code_q(app_code)
  );

  tscr_code_slot u_meas_slot (
    .clock(clock),
    .rst_b(rst_b),
    .clear(clear_all),
    .load(meas_load),
    .load_code(meas_load_code),
    .code_q(meas_code)
  );

  tscr_code_slot u_alg_slot (
    .clock(clock),
    .rst_b(rst_b),
    .clear(clear_all),
    .load(alg_load),
    .load_code(alg_load_code),
    .code_q(alg_code)
  );

  tscr_code_slot u_cal_slot (
    .clock(clock),
    .rst_b(rst_b),
    .clear(clear_all),
    .load(cal_load),
    .load_code(cal_load_code),
    .code_q(cal_code)
  );

  // **************************************************************************
  // Register port, interrupt flag and shutdown request.
  // **************************************************************************

  // Next-state logic for the port, the flag, the mask and the shutdown pulse.
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = reg_rd;
    state_next.shutdown = measurement_stop_failed;
    if (reg_rd) begin
      unique case (reg_addr)
        tscr_pkg::TSCR_OFF_APP: state_next.rdata = app_code;
        tscr_pkg::TSCR_OFF_MEAS: state_next.rdata = meas_code;
        tscr_pkg::TSCR_OFF_ALG: state_next.rdata = alg_code;
        tscr_pkg::TSCR_OFF_CAL: state_next.rdata = cal_code;
        tscr_pkg::TSCR_OFF_INT_FLAG: begin
          state_next.rdata = 8'h00;
          state_next.rdata[tscr_pkg::TSCR_IRQ_BIT] = state_reg.irq_flag;
        end
        tscr_pkg::TSCR_OFF_INT_MASK: begin
          state_next.rdata = 8'h00;
          state_next.rdata[tscr_pkg::TSCR_IRQ_BIT] = state_reg.irq_mask;
        end
        default: state_next.rdata = 8'h00;
      endcase
    end
    if (reg_wr && reg_addr == tscr_pkg::TSCR_OFF_INT_MASK) begin
      state_next.irq_mask = reg_wdata[tscr_pkg::TSCR_IRQ_BIT];
    end
    // Writing one clears the flag, but a new nonzero code sets it again.
    if (reg_wr && reg_addr == tscr_pkg::TSCR_OFF_INT_FLAG &&
        reg_wdata[tscr_pkg::TSCR_IRQ_BIT]) begin
      state_next.irq_flag = 1'b0;
    end
    if (any_nonzero_load) begin
      state_next.irq_flag = 1'b1;
    end
  end

  // State register of the block.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{irq_flag: tscr_pkg::TSCR_FLAG_RESET,
                     irq_mask: tscr_pkg::TSCR_MASK_RESET,
                     rdata: tscr_pkg::TSCR_CODE_RESET,
                     rvalid: 1'b0,
                     shutdown: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs: the interrupt pin is pulled low only while flag and mask are set.
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign measurement_forced_shutdown = state_reg.shutdown;
  assign status_nonzero_irq_flag = state_reg.irq_flag;
  assign int_pin_o = 1'b0;
  assign int_pin_oe_b = !(state_reg.irq_flag && state_reg.irq_mask);

  // **************************************************************************
  // Assertions.
  // **************************************************************************
  sequence s_stop_fail;
    measurement_stop_failed && !(|app_ev[0]);
  endsequence

  sequence s_shutdown_seen;
    measurement_forced_shutdown && app_code == tscr_pkg::TSCR_APP_SHUTDOWN;
  endsequence

  sequence s_read_req(logic [7:0] off);
    reg_rd && reg_addr == off;
  endsequence

  a_shutdown_code: assert property (@(posedge clock) disable iff (!rst_b)
    s_stop_fail |=> s_shutdown_seen)
    else $error("Forced shutdown did not report code 0x02.");

  a_app_selftest: assert property (@(posedge clock) disable iff (!rst_b)
    histogram_ram_selftest_fail |=> app_code == 8'h01)
    else $error("Self-test failure did not report code 0x01.");

  a_app_fuse: assert property (@(posedge clock) disable iff (!rst_b)
    (app_ev[4:0] == 5'h10) |=> app_code == 8'h05)
    else $error("Unprogrammed fuses did not report code 0x05.");

  a_meas_lockup: assert property (@(posedge clock) disable iff (!rst_b)
    (meas_ev == 6'h20) |=> meas_code == 8'h18)
    else $error("Converter lockup did not report code 0x18.");

  a_meas_eye: assert property (@(posedge clock) disable iff (!rst_b)
    emitter_eye_safety_fault |=> meas_code == 8'h11)
    else $error("Eye-safety failure did not report code 0x11.");

  a_alg_mismatch: assert property (@(posedge clock) disable iff (!rst_b)
    (alg_ev == 6'h04) |=> alg_code == 8'h23)
    else $error("Index mismatch did not report code 0x23.");

  a_cal_absent: assert property (@(posedge clock) disable iff (!rst_b)
    absent_factory_cal_warning |=> cal_code == 8'h31)
    else $error("Missing calibration did not report code 0x31.");

  a_clear_all: assert property (@(posedge clock) disable iff (!rst_b)
    (clear_all && !any_nonzero_load) |=>
      (app_code | meas_code | alg_code | cal_code) == 8'h00)
    else $error("Clear command left a status code set.");

  a_meas_reserved: assert property (@(posedge clock) disable iff (!rst_b)
    meas_code != 8'h13 && meas_code != 8'h14 && alg_code[7:4] != 4'h1)
    else $error("A reserved status code was reported.");

  a_read_meas: assert property (@(posedge clock) disable iff (!rst_b)
    s_read_req(tscr_pkg::TSCR_OFF_MEAS) |=> reg_rvalid && reg_rdata == $past(meas_code))
    else $error("Read of the measurement register returned a wrong value.");

  a_read_noeffect: assert property (@(posedge clock) disable iff (!rst_b)
    (reg_rd && !reg_wr && !app_load) |=> app_code == $past(app_code))
    else $error("A read changed the application status code.");

  // Mask copy for the pin check, declared ahead of its first use.
  logic irq_mask_q;
  assign irq_mask_q = state_reg.irq_mask;

  a_irq_set: assert property (@(posedge clock) disable iff (!rst_b)
    any_nonzero_load |=> status_nonzero_irq_flag [*1] ##0
      (int_pin_oe_b == !irq_mask_q))
    else $error("Nonzero status did not raise the flag and pin as masked.");

  a_pin_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !status_nonzero_irq_flag |-> int_pin_oe_b)
    else $error("Interrupt pin pulled low without the flag.");

endmodule

/* File: inc/tscr_pkg.sv */
// ****************************************************************************
// Status code register group: shared constants.
// ****************************************************************************
package tscr_pkg;

  // **************************************************************************
  // Register offsets on the serial register port.
  // **************************************************************************
  localparam logic [7:0] TSCR_OFF_APP = 8'h04;
  localparam logic [7:0] TSCR_OFF_MEAS = 8'h05;
  localparam logic [7:0] TSCR_OFF_ALG = 8'h06;
  localparam logic [7:0] TSCR_OFF_CAL = 8'h07;
  localparam logic [7:0] TSCR_OFF_CMD = 8'h08;
  localparam logic [7:0] TSCR_OFF_INT_FLAG = 8'hE1;
  localparam logic [7:0] TSCR_OFF_INT_MASK = 8'hE2;

  // **************************************************************************
  // Field positions, reset values and commands.
  // **************************************************************************
  localparam int TSCR_IRQ_BIT = 6;
  localparam logic [7:0] TSCR_CODE_RESET = 8'h00;
  localparam logic [7:0] TSCR_CODE_NONE = 8'h00;
  localparam logic TSCR_FLAG_RESET = 1'b0;
  localparam logic TSCR_MASK_RESET = 1'b0;
  localparam logic [7:0] TSCR_CMD_MEASURE = 8'h10;
  localparam logic [7:0] TSCR_CMD_CLEAR = 8'h11;
  localparam int TSCR_EV_MAX = 6;

  // **************************************************************************
  // Code tables, entry 0 has the highest priority.
  // **************************************************************************
  localparam logic [5:0][7:0] TSCR_APP_CODES = {8'h00, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
  localparam logic [5:0][7:0] TSCR_MEAS_CODES = {8'h18, 8'h17, 8'h16, 8'h15, 8'h12, 8'h11};
  localparam logic [5:0][7:0] TSCR_ALG_CODES = {8'h00, 8'h00, 8'h00, 8'h23, 8'h22, 8'h21};
  localparam logic [5:0][7:0] TSCR_CAL_CODES = {8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h31};
  localparam int TSCR_APP_N = 5;
  localparam int TSCR_MEAS_N = 6;
  localparam int TSCR_ALG_N = 3;
  localparam int TSCR_CAL_N = 2;

  // Shutdown code reported when the measurement machine is forced down.
  localparam logic [7:0] TSCR_APP_SHUTDOWN = 8'h02;
  localparam int TSCR_APP_SHUTDOWN_IDX = 1;

  // Returns the first code whose event bit is set, or zero when none is.
  function automatic logic [7:0] tscr_pick(input logic [5:0] ev,
                                           input logic [5:0][7:0] tab,
                                           input int n);
    logic [7:0] code;
    code = TSCR_CODE_NONE;
    for (int i = TSCR_EV_MAX - 1; i >= 0; i--) begin
      if (i < n && ev[i]) begin
        code = tab[i];
      end
    end
    return code;
  endfunction

endpackage

/* File: tb/tb_tscr_status_regs.sv */
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the status code register group.
// ************************************************************
module tb_tscr_status_regs;
  // Event inputs in port order; the code's upper nibble selects the register.
  localparam logic [15:0][7:0] CODES = {8'h32, 8'h31, 8'h23, 8'h22, 8'h21, 8'h18, 8'h17,
    8'h16, 8'h15, 8'h12, 8'h11, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
  localparam logic [3:0][7:0] CMDS = {8'hFF, 8'h12, 8'h11, 8'h10};
  logic clock, rst_b, reg_rd, reg_wr, reg_rvalid, shut, flag, pin_o, pin_oe_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
  logic [15:0] ev, v;
  logic [3:0][7:0] exp_code;
  logic exp_flag, exp_mask;
  int n_fail, comparisons, seed;

  tscr_status_regs tscr_status_regs_inst (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .histogram_ram_selftest_fail(ev[0]), .measurement_stop_failed(ev[1]),
    .sleep_timer_range_fault(ev[2]), .unplanned_reset_seen(ev[3]),
    .unprogrammed_fuse_warning(ev[4]), .emitter_eye_safety_fault(ev[5]),
    .breakdown_voltage_search_fault(ev[6]), .extra_configuration_fault(ev[7]),
    .start_before_setup_fault(ev[8]), .buffer_double_return_fault(ev[9]),
    .converter_lockup_fault(ev[10]), .electrical_cal_fault(ev[11]),
    .electrical_cal_missing_buffer(ev[12]), .electrical_cal_index_mismatch(ev[13]),
    .absent_factory_cal_warning(ev[14]), .factory_cal_mask_mismatch(ev[15]),
    .measurement_forced_shutdown(shut), .status_nonzero_irq_flag(flag),
    .int_pin_o(pin_o), .int_pin_oe_b(pin_oe_b));

  tscr_host_model tscr_host_model_inst (.clock(clock), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ************************************************************
  // Checking and expectation helpers.
  // ************************************************************
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    logic ok;
    tscr_host_model_inst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no read answer", $time);
      close_out();
    end else begin
      check(d, want, "read data");
    end
  endtask

  // Lowest code per register wins; untouched registers keep their code.
  function automatic logic [3:0][7:0] apply(input logic [3:0][7:0] cur, input logic [15:0] e);
    logic [3:0][7:0] nxt;
    logic [3:0] hit;
    nxt = cur;
    hit = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (e[i] && !hit[CODES[i][5:4]]) begin
        nxt[CODES[i][5:4]] = CODES[i];
        hit[CODES[i][5:4]] = 1'b1;
      end
    end
    return nxt;
  endfunction

  // Reads the four codes and the flag register.
  task automatic check_all();
    for (int r = 0; r < 4; r++) begin
      read_chk(8'h04 + 8'(r), exp_code[r]);
    end
    read_chk(8'hE1, {1'b0, exp_flag, 6'h00});
  endtask

  // Pulses events for one cycle and checks shutdown, flag and pin.
  task automatic pulse(input logic [15:0] e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= 16'h0000;
    exp_code = apply(exp_code, e);
    exp_flag = exp_flag | (|e);
    @(posedge clock);
    check({7'h00, shut}, {7'h00, e[1]}, "shutdown pulse");
    check({6'h00, flag, pin_o}, {6'h00, exp_flag, 1'b0}, "flag");
    check({7'h00, pin_oe_b}, {7'h00, !(exp_flag && exp_mask)}, "pin");
    @(posedge clock);
    check({7'h00, shut}, 8'h00, "shutdown width");
  endtask

  // Issues a command; measure and clear-status empty all codes.
  task automatic cmd(input logic [7:0] d);
    tscr_host_model_inst.wr(8'h08, d);
    if (d == 8'h10 || d == 8'h11) begin
      exp_code = '0;
    end
  endtask

  // Writes the mask or clears the flag, then checks the pin.
  task automatic irq_wr(input logic [7:0] a, input logic [7:0] d);
    tscr_host_model_inst.wr(a, d);
    if (a == 8'hE2) begin
      exp_mask = d[6];
    end else if (d[6]) begin
      exp_flag = 1'b0;
    end
    @(posedge clock);
    check({7'h00, pin_oe_b}, {7'h00, !(exp_flag && exp_mask)}, "pin");
  endtask

  // ************************************************************
  // Clock and main sequence.
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    seed = 64152;
    n_fail = 0;
    comparisons = 0;
    rst_b = 1'b0;
    ev = 16'h0000;
    exp_code = '0;
    exp_flag = 1'b0;
    exp_mask = 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    check({7'h00, pin_oe_b}, 8'h01, "pin after reset");
    check_all();
    read_chk(8'h30, 8'h00);
    // Every code alone, after a clear.
    for (int i = 0; i < 16; i++) begin
      cmd(8'h11);
      pulse(16'h0001 << i);
      check_all();
    end
    // Host writes to the codes are ignored and reads change nothing.
    for (int r = 0; r < 4; r++) begin
      tscr_host_model_inst.wr(8'h04 + 8'(r), ~exp_code[r]);
    end
    check_all();
    irq_wr(8'hE2, 8'hBF);
    irq_wr(8'hE2, 8'h40);
    read_chk(8'hE2, 8'h40);
    irq_wr(8'hE1, 8'h40);
    pulse(16'h0021);
    cmd(8'h12);
    check_all();
    cmd(8'h10);
    check_all();
    // Random sparse events, commands and mask changes.
    repeat (40) begin
      v = 16'($random(seed) & $random(seed) & $random(seed));
      pulse(v);
      c = 8'($random(seed));
      if (c[1:0] == 2'b00) begin
        cmd(CMDS[c[3:2]]);
      end else if (c[1:0] == 2'b01) begin
        irq_wr(c[4] ? 8'hE1 : 8'hE2, 8'($random(seed)));
      end
      check_all();
    end
    // Reset in mid-run returns codes, flag and mask to zero and releases the pin.
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    exp_code = '0;
    exp_flag = 1'b0;
    exp_mask = 1'b0;
    check({7'h00, pin_oe_b}, 8'h01, "pin after reset");
    check_all();
    read_chk(8'hE2, 8'h00);
    close_out();
  end
endmodule

/* File: tb/tscr_host_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Host side of the register port: strobed reads and writes.
// ************************************************************
module tscr_host_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle values at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle read strobe, then wait a bounded time for the answer.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a; // Released lines show no stale address.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask

  // One-cycle write strobe; writes carry no answer.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
